// >>> rwseq_pkg.sv
// Package of the reset and wake-up sequencer: timing figures, cycle counts,
// configuration and event carriers, and the sequencer states.
// Assumes a single system clock at the rate given by clk_period_ns.
package rwseq_pkg;

   // ***************************************************************
   // Clock and timing figures
   // ***************************************************************
   localparam real clk_period_ns   = 10.0;
   localparam real pwrup_t0_us     = 140.0;
   localparam real pwrup_t1_ms     = 4.5;
   localparam real pwrup_t2_ms     = 18.0;
   localparam real pwrup_t3_ms     = 72.0;
   localparam real pwrup_t4_ms     = 288.0;

   // Least times round up to whole cycles
   localparam int unsigned pwrup_cyc0 = int'($ceil(pwrup_t0_us * 1000.0 / clk_period_ns));
   localparam int unsigned pwrup_cyc1 = int'($ceil(pwrup_t1_ms * 1000000.0 / clk_period_ns));
   localparam int unsigned pwrup_cyc2 = int'($ceil(pwrup_t2_ms * 1000000.0 / clk_period_ns));
   localparam int unsigned pwrup_cyc3 = int'($ceil(pwrup_t3_ms * 1000000.0 / clk_period_ns));
   localparam int unsigned pwrup_cyc4 = int'($ceil(pwrup_t4_ms * 1000000.0 / clk_period_ns));

   localparam int          cnt_w         = 25;
   localparam int unsigned wake_xtal_cyc = 512;
   localparam int unsigned wake_rc_cyc   = 16;
   localparam int unsigned ost_cyc       = 16;

   // ***************************************************************
   // Selector codes and vector
   // ***************************************************************
   localparam logic [2:0]  pwrup_sel0 = 3'h0;
   localparam logic [2:0]  pwrup_sel1 = 3'h1;
   localparam logic [2:0]  pwrup_sel2 = 3'h2;
   localparam logic [2:0]  pwrup_sel3 = 3'h3;
   localparam int          pc_w       = 12;
   localparam logic [11:0] isr_vector = 12'h008;

   // ***************************************************************
   // Carriers
   // ***************************************************************
   typedef struct packed {
      logic       external_low_crystal;
      logic [2:0] pwrup_sel;
      logic       high_osc_select;
   } cfg_t;

   typedef struct packed {
      logic timer_a_overflow;
      logic timer_b_underflow;
      logic watchdog;
      logic port_b_change;
      logic ext_irq;
   } wake_src_t;

   typedef struct packed {
      logic timeout_flag_n;
      logic powerdown_flag_n;
   } status_t;

   typedef enum logic [2:0] {
      st_reset_hold,
      st_pwrup_wait,
      st_ost_wait,
      st_run,
      st_standby,
      st_halt,
      st_wake_wait
   } seq_state_t;

endpackage : rwseq_pkg

// >>> level_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes a synchronous active-low reset and a clock enable that freezes it.
`timescale 1ns/1ps
module level_sync #(
   parameter logic rst_val = 1'b0
) (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic clk_en,
   input  wire logic async_in,
   output logic      sync_out
);

   logic stage1;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         stage1   <= rst_val;
         sync_out <= rst_val;
      end else if (clk_en) begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : level_sync

// >>> wait_counter.sv
// Loadable down counter that times the sequencer's wait periods.
// Assumes the loader puts in the period minus one; done is high at zero.
`timescale 1ns/1ps
module wait_counter
   import rwseq_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             clk_en,
   input  wire logic             load,
   input  wire logic [cnt_w-1:0] load_val,
   output logic                  done
);

   logic [cnt_w-1:0] count;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         count <= '0;
      end else if (clk_en) begin
         if (load) begin
            count <= load_val;
         end else if (count != '0) begin
            count <= count - cnt_w'(1);
         end
      end
   end

   assign done = (count == '0);

endmodule : wait_counter

// >>> mcu_reset_wake_sequencer.sv
// Reset, power-up and low-power wake-up sequencer of a small microcontroller.
// Assumes the CPU core, oscillators and wake sources share ref_clk; the reset
// pin and the supply detectors arrive asynchronously.
`timescale 1ns/1ps

// Behaviour
// RULE1 - Halt wake with crystal waits 512 cycles
// RULE2 - Halt wake with RC oscillator waits 16
// RULE3 - Standby wake resumes without stabilisation delay
// RULE4 - Interrupts enabled at entry: branch to 0x008
// RULE5 - Interrupts disabled at entry: continue next instruction
// RULE6 - Reset on power-on, low-voltage, pin, watchdog
// RULE7 - Reset loads defined values, keeps undefined ones
// RULE8 - Power-on, low-voltage, watchdog clear set both flags
// RULE9 - Pin reset outside halt keeps both flags
// RULE10 - Pin reset in halt: timeout 1, powerdown 0
// RULE11 - Watchdog reset outside halt: timeout 0, powerdown 1
// RULE12 - Watchdog reset in halt clears both flags
// RULE13 - Reset process starts after event release
// RULE14 - Selectable power-up wait 140us to 288ms
// RULE15 - Then 16 start-up cycles, then execute
// RULE16 - Standby wakes on five listed events
// RULE17 - Halt wakes on watchdog, port change, interrupt
// RULE18 - Resume normal if high select, else slow
// RULE19 - Sleep clears powerdown, sets timeout flag
// RULE20 - Wake counter holds fetch until count completes
// RULE21 - Event during waits restarts whole reset process
module mcu_reset_wake_sequencer #(
   parameter int unsigned pwrup_cyc_0 = rwseq_pkg::pwrup_cyc0,
   parameter int unsigned pwrup_cyc_1 = rwseq_pkg::pwrup_cyc1,
   parameter int unsigned pwrup_cyc_2 = rwseq_pkg::pwrup_cyc2,
   parameter int unsigned pwrup_cyc_3 = rwseq_pkg::pwrup_cyc3,
   parameter int unsigned pwrup_cyc_4 = rwseq_pkg::pwrup_cyc4
) (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire logic                clk_en,
   input  wire logic                por_event,
   input  wire logic                lvr_event,
   input  wire logic                external_reset_n,
   input  wire logic                wdt_timeout_reset,
   input  wire rwseq_pkg::cfg_t     cfg,
   input  wire logic                sleep_instr,
   input  wire logic                halt_request,
   input  wire logic                standby_request,
   input  wire logic                watchdog_clear_instr,
   input  wire logic                global_irq_enabled,
   input  wire rwseq_pkg::wake_src_t wake_src,
   output logic                     cpu_reset,
   output logic                     fetch_hold,
   output logic                     osc_halted,
   output logic                     resume_strobe,
   output logic                     branch_to_isr,
   output logic [rwseq_pkg::pc_w-1:0] resume_vector,
   output logic                     normal_mode,
   output rwseq_pkg::status_t       status
);
   import rwseq_pkg::*;

   // ***************************************************************
   // Input synchronisers
   // ***************************************************************
   logic por_s;
   logic lvr_s;
   logic ext_rst_n_s;

   level_sync #(.rst_val(1'b0)) u_por_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .async_in (por_event),
      .sync_out (por_s)
   );

   level_sync #(.rst_val(1'b0)) u_lvr_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .async_in (lvr_event),
      .sync_out (lvr_s)
   );

   level_sync #(.rst_val(1'b1)) u_pin_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .async_in (external_reset_n),
      .sync_out (ext_rst_n_s)
   );

   // ***************************************************************
   // Reset event detection
   // ***************************************************************
   logic       supply_prev;
   logic       pin_low_prev;
   logic       supply_evt;
   logic       supply_rise;
   logic       pin_rise;
   logic       any_reset_event;
   seq_state_t state;
   seq_state_t next_state;
   logic       in_halt;

   assign supply_evt      = por_s | lvr_s;
   assign supply_rise     = supply_evt & ~supply_prev;
   assign pin_rise        = ~ext_rst_n_s & ~pin_low_prev;
   // Wake-up wait still counts as halt for flag purposes
   assign in_halt         = (state == st_halt) || (state == st_wake_wait);
   assign any_reset_event = supply_evt | ~ext_rst_n_s | wdt_timeout_reset;   // see RULE6

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         supply_prev  <= 1'b0;
         pin_low_prev <= 1'b0;
      end else if (clk_en) begin
         supply_prev  <= supply_evt;
         pin_low_prev <= ~ext_rst_n_s;
      end
   end

   // ***************************************************************
   // Wait timer
   // ***************************************************************
   logic             cnt_load;
   logic [cnt_w-1:0] cnt_val;
   logic             cnt_done;
   logic [cnt_w-1:0] pwrup_len;
   logic [cnt_w-1:0] wake_len;

   // Periods are loaded minus one so a wait of N spends N cycles in its state
   always_comb begin
      case (cfg.pwrup_sel)                                                   // see RULE14
         pwrup_sel0: pwrup_len = cnt_w'(pwrup_cyc_0 - 1);
         pwrup_sel1: pwrup_len = cnt_w'(pwrup_cyc_1 - 1);
         pwrup_sel2: pwrup_len = cnt_w'(pwrup_cyc_2 - 1);
         pwrup_sel3: pwrup_len = cnt_w'(pwrup_cyc_3 - 1);
         default:    pwrup_len = cnt_w'(pwrup_cyc_4 - 1);
      endcase
   end

   assign wake_len = cfg.external_low_crystal ? cnt_w'(wake_xtal_cyc - 1)   // see RULE1
                                              : cnt_w'(wake_rc_cyc - 1);    // see RULE2

   wait_counter u_wait (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .load     (cnt_load),
      .load_val (cnt_val),
      .done     (cnt_done)
   );

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   logic halt_wake;
   logic standby_wake;
   logic enter_halt;

   assign halt_wake    = wake_src.watchdog | wake_src.port_b_change
                       | wake_src.ext_irq;                                   // see RULE17
   assign standby_wake = halt_wake | wake_src.timer_a_overflow
                       | wake_src.timer_b_underflow;                         // see RULE16
   assign enter_halt   = sleep_instr | halt_request;

   always_comb begin
      next_state = state;
      cnt_load   = 1'b0;
      cnt_val    = pwrup_len;
      if (any_reset_event) begin
         // Held here until every event is gone, restarting the sequence
         next_state = st_reset_hold;                                         // see RULE13
      end else begin
         case (state)
            st_reset_hold: begin
               next_state = st_pwrup_wait;                                   // see RULE21
               cnt_load   = 1'b1;
               cnt_val    = pwrup_len;
            end
            st_pwrup_wait: begin
               if (cnt_done) begin
                  next_state = st_ost_wait;                                  // see RULE15
                  cnt_load   = 1'b1;
                  cnt_val    = cnt_w'(ost_cyc - 1);
               end
            end
            st_ost_wait: begin
               if (cnt_done) begin
                  next_state = st_run;
               end
            end
            st_run: begin
               if (enter_halt) begin
                  next_state = st_halt;
               end else if (standby_request) begin
                  next_state = st_standby;
               end
            end
            st_standby: begin
               if (standby_wake) begin
                  next_state = st_run;                                       // see RULE3
               end
            end
            st_halt: begin
               if (halt_wake) begin
                  next_state = st_wake_wait;
                  cnt_load   = 1'b1;
                  cnt_val    = wake_len;
               end
            end
            st_wake_wait: begin
               if (cnt_done) begin
                  next_state = st_run;                                       // see RULE20
               end
            end
            default: begin
               next_state = st_reset_hold;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= st_reset_hold;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // ***************************************************************
   // Core control outputs
   // ***************************************************************
   logic irq_at_entry;
   logic resuming;

   assign resuming = (next_state == st_run) && (state != st_run);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_at_entry <= 1'b0;
      end else if (clk_en && state == st_run && next_state != st_run) begin
         irq_at_entry <= global_irq_enabled;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cpu_reset  <= 1'b1;
         fetch_hold <= 1'b1;
         osc_halted <= 1'b0;
      end else if (clk_en) begin
         // Core registers reload their defined values while this is high
         cpu_reset  <= (next_state == st_reset_hold) || (next_state == st_pwrup_wait)
                       || (next_state == st_ost_wait);                        // see RULE7
         fetch_hold <= (next_state != st_run);                                // see RULE20
         osc_halted <= (next_state == st_halt);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         resume_strobe <= 1'b0;
         branch_to_isr <= 1'b0;
         resume_vector <= '0;
      end else if (clk_en) begin
         resume_strobe <= resuming && (state != st_ost_wait);
         if (resuming && state != st_ost_wait) begin
            branch_to_isr <= irq_at_entry;                                    // see RULE4
            resume_vector <= irq_at_entry ? isr_vector : '0;                  // see RULE5
         end else begin
            branch_to_isr <= 1'b0;
            resume_vector <= '0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         normal_mode <= 1'b0;
      end else if (clk_en && resuming) begin
         normal_mode <= cfg.high_osc_select;                                  // see RULE18
      end
   end

   // ***************************************************************
   // Timeout and power-down flags
   // ***************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         status <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1};
      end else if (clk_en) begin
         if (supply_rise) begin
            status <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1};      // see RULE8
         end else if (wdt_timeout_reset && in_halt) begin
            status <= '{timeout_flag_n: 1'b0, powerdown_flag_n: 1'b0};      // see RULE12
         end else if (wdt_timeout_reset) begin
            status <= '{timeout_flag_n: 1'b0, powerdown_flag_n: 1'b1};      // see RULE11
         end else if (pin_rise && in_halt) begin
            status <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b0};      // see RULE10
         end else if (pin_rise) begin
            status <= status;                                                 // see RULE9
         end else if (state == st_run && watchdog_clear_instr) begin
            status <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1};      // see RULE8
         end else if (state == st_run && enter_halt) begin
            status <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b0};      // see RULE19
         end
      end
   end

endmodule : mcu_reset_wake_sequencer

// >>> rwseq_wake_model.sv
// Model of the wake-up event sources beside the sequencer.
// Assumes the bench pulses fire for one cycle; the event goes out dly+1 cycles after the edge that samples fire.
`timescale 1ns/1ps
module wake_model (
   input  wire logic           ref_clk,
   input  wire logic           rst_n,
   input  wire logic           fire,
   input  wire logic [2:0]     src,
   input  wire logic [3:0]     dly,
   output rwseq_pkg::wake_src_t wake_src
);
   import rwseq_pkg::*;
   // ***************************************************************
   // One-cycle event, prompt or late
   // ***************************************************************
   logic [4:0] left;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         left     <= 5'h00;
         wake_src <= '0;
      end else begin
         wake_src <= '0;
         if (fire) left <= {1'b0, dly} + 5'h01;
         else if (left != 5'h00) left <= left - 5'h01;
         if (left == 5'h01) wake_src <= wake_src_t'(5'h10 >> src);
      end
   end
endmodule : wake_model

// >>> mcu_reset_wake_sequencer_properties.sv
// Port checker of the reset and wake-up sequencer.
// Assumes clk_en is high while any property runs; bound to every sequencer instance.
`timescale 1ns/1ps
module rwseq_props (
   input wire logic                   ref_clk,
   input wire logic                   rst_n,
   input wire logic                   clk_en,
   input wire logic                   por_event,
   input wire logic                   lvr_event,
   input wire logic                   external_reset_n,
   input wire logic                   wdt_timeout_reset,
   input wire rwseq_pkg::cfg_t        cfg,
   input wire logic                   sleep_instr,
   input wire logic                   halt_request,
   input wire logic                   standby_request,
   input wire logic                   watchdog_clear_instr,
   input wire logic                   global_irq_enabled,
   input wire rwseq_pkg::wake_src_t   wake_src,
   input wire logic                   cpu_reset,
   input wire logic                   fetch_hold,
   input wire logic                   osc_halted,
   input wire logic                   resume_strobe,
   input wire logic                   branch_to_isr,
   input wire logic [rwseq_pkg::pc_w-1:0] resume_vector,
   input wire logic                   normal_mode,
   input wire rwseq_pkg::status_t     status
);
   import rwseq_pkg::*;
   // ***************************************************************
   // Properties
   // ***************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic async_q, quiet, hwake;
   assign async_q = external_reset_n && !por_event && !lvr_event && clk_en;
   assign quiet   = async_q && !wdt_timeout_reset;
   assign hwake   = wake_src.watchdog | wake_src.port_b_change | wake_src.ext_irq;
   a_halt_xtal_wake : assert property (
      osc_halted && hwake && quiet && cfg.external_low_crystal |-> ##[513:513] resume_strobe)
      else $error("crystal halt wake length wrong");
   a_halt_rc_wake : assert property (
      osc_halted && hwake && quiet && !cfg.external_low_crystal |-> ##17 resume_strobe)
      else $error("rc halt wake length wrong");
   a_wake_holds_fetch : assert property (
      osc_halted && hwake && quiet |=> fetch_hold && !osc_halted) else $error("fetch not held in wake wait");
   a_vector_match : assert property (
      resume_strobe |-> resume_vector == (branch_to_isr ? isr_vector : 12'h000)) else $error("resume vector wrong");
   a_sleep_flags : assert property (
      !fetch_hold && (sleep_instr || halt_request) && !watchdog_clear_instr && quiet
      |=> status == 2'b10 && osc_halted) else $error("sleep flags wrong");
   a_clear_flags : assert property (
      !fetch_hold && watchdog_clear_instr && quiet |=> status == 2'b11) else $error("clear flags wrong");
   a_wdt_run_flags : assert property (
      !fetch_hold && wdt_timeout_reset && async_q |=> status == 2'b01 && cpu_reset)
      else $error("watchdog reset flags wrong");
   a_wdt_halt_flags : assert property (
      osc_halted && wdt_timeout_reset && async_q |=> status == 2'b00 && cpu_reset)
      else $error("watchdog halt reset flags wrong");
   a_pin_held_reset : assert property (
      !external_reset_n [*5] |-> cpu_reset && fetch_hold) else $error("pin reset not held");
   a_timer_ignored : assert property (
      osc_halted && (wake_src.timer_a_overflow || wake_src.timer_b_underflow) && !hwake && quiet
      |=> osc_halted) else $error("timer woke halt");
   a_mode_latch : assert property (
      resume_strobe |-> normal_mode == $past(cfg.high_osc_select)) else $error("resume mode wrong");
   c_isr_resume : cover property (resume_strobe && branch_to_isr);
   c_next_resume : cover property (resume_strobe && !branch_to_isr);
   c_boot_done : cover property ($fell(cpu_reset));
endmodule : rwseq_props

bind mcu_reset_wake_sequencer rwseq_props props_u (.ref_clk, .rst_n, .clk_en, .por_event, .lvr_event,
   .external_reset_n, .wdt_timeout_reset, .cfg, .sleep_instr, .halt_request, .standby_request,
   .watchdog_clear_instr, .global_irq_enabled, .wake_src, .cpu_reset, .fetch_hold, .osc_halted,
   .resume_strobe, .branch_to_isr, .resume_vector, .normal_mode, .status);

// >>> mcu_reset_wake_sequencer_tb_top.sv
// Self-checking bench of the reset and wake-up sequencer.
// Assumes the wake model drives wake_src; clk_en drops only for four edges of one boot.
`timescale 1ns/1ps
module mcu_reset_wake_sequencer_tb_top;
   import rwseq_pkg::*;
   // ***************************************************************
   // Signals and instances
   // ***************************************************************
   logic        ref_clk, rst_n, clk_en, por_event, lvr_event, external_reset_n;
   logic        wdt_timeout_reset, sleep_instr, halt_request, standby_request;
   logic        watchdog_clear_instr, global_irq_enabled, fire, irq;
   logic        cpu_reset, fetch_hold, osc_halted, resume_strobe, branch_to_isr, normal_mode;
   logic [2:0]  src;
   logic [3:0]  dly;
   logic [11:0] resume_vector;
   cfg_t        cfg;
   wake_src_t   wake_src;
   status_t     status;
   int          bad_count, n_compared, cycles, cnt;
   int          ev_kind[7]  = '{0, 2, 3, 1, 3, 0, 3};
   int          ev_halt[7]  = '{0, 0, 0, 0, 0, 1, 1};
   int          ev_flags[7] = '{1, 3, 1, 3, 1, 2, 0};
   mcu_reset_wake_sequencer #(.pwrup_cyc_0(20), .pwrup_cyc_1(30), .pwrup_cyc_2(40), .pwrup_cyc_3(50),
      .pwrup_cyc_4(60)) dut_u (.ref_clk, .rst_n, .clk_en, .por_event, .lvr_event, .external_reset_n,
      .wdt_timeout_reset, .cfg, .sleep_instr, .halt_request, .standby_request, .watchdog_clear_instr,
      .global_irq_enabled, .wake_src, .cpu_reset, .fetch_hold, .osc_halted, .resume_strobe,
      .branch_to_isr, .resume_vector, .normal_mode, .status);
   wake_model wake_u (.ref_clk, .rst_n, .fire, .src, .dly, .wake_src);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end
   // ***************************************************************
   // Tasks
   // ***************************************************************
   function automatic int pwr_len(input logic [2:0] sel);
      return (sel > 3'h3) ? 60 : 20 + 10 * int'(sel);
   endfunction : pwr_len
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step
   task automatic wait_for(input int what, input int lim);
      cnt = 0;
      do begin
         step(1);
         cnt++;
      end while (cnt < lim && !(what == 0 ? fetch_hold === 1'b0 :
                 what == 1 ? resume_strobe === 1'b1 : wake_src !== '0));
   endtask : wait_for
   task automatic kick(input logic [2:0] s);
      src = s;
      dly = 4'($urandom_range(7));
      fire = 1'b1;
      step(1);
      fire = 1'b0;
      wait_for(2, 20);
   endtask : kick
   task automatic resume(input int exp);
      wait_for(1, 600);
      check("wake length", 16'(cnt), 16'(exp));
      check("branch", 16'(branch_to_isr), 16'(irq));
      check("vector", 16'(resume_vector), irq ? 16'h0008 : 16'h0000);
      check("mode", 16'(normal_mode), 16'(cfg.high_osc_select));
   endtask : resume
   task automatic go_halt(input logic x, input logic i);
      cfg.external_low_crystal = x;
      global_irq_enabled = i;
      if ($urandom_range(1) == 1) sleep_instr = 1'b1;
      else halt_request = 1'b1;
      step(1);
      {sleep_instr, halt_request} = 2'b00;
      global_irq_enabled = ~i;
      check("halt flags", 16'(status), 16'h0002);
   endtask : go_halt
   task automatic evt(input int k);
      case (k)
         0: external_reset_n = 1'b0;
         1: por_event = 1'b1;
         2: lvr_event = 1'b1;
         default: wdt_timeout_reset = 1'b1;
      endcase
      step(k == 3 ? 1 : 5);
      check("in reset", 16'(cpu_reset), 16'h0001);
      external_reset_n = 1'b1;
      {por_event, lvr_event, wdt_timeout_reset} = 3'h0;
      wait_for(0, 400);
      check("back to run", 16'(fetch_hold), 16'h0000);
   endtask : evt
   task automatic complete_run();
      if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run
   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      {rst_n, por_event, lvr_event, wdt_timeout_reset, sleep_instr, halt_request} = '0;
      {standby_request, watchdog_clear_instr, global_irq_enabled, fire, irq} = '0;
      {clk_en, external_reset_n, src, dly, cfg} = {2'b11, 12'h000};
      {bad_count, n_compared, cycles} = '0;
      void'($urandom(31));
      step(20);
      check("reset status", 16'(status), 16'h0003);
      check("reset strobe", 16'(resume_strobe), 16'h0000);
      for (int i = 0; i < 8; i++) begin
         cfg.pwrup_sel = 3'(i);
         cfg.high_osc_select = i[0];
         rst_n = 1'b0;
         step(3);
         rst_n = 1'b1;
         // One boot runs with the clock enable low for four edges: all state must freeze
         clk_en = (i != 5);
         step(4);
         clk_en = 1'b1;
         wait_for(0, 300);
         check("boot length", 16'(cnt), 16'(pwr_len(3'(i)) + ((i == 5) ? 17 : 13)));
         check("boot mode", 16'(normal_mode), 16'(i[0]));
      end
      rst_n = 1'b0;
      step(3);
      rst_n = 1'b1;
      step(5 + $urandom_range(60));
      wdt_timeout_reset = 1'b1;
      step(1);
      wdt_timeout_reset = 1'b0;
      wait_for(0, 300);
      check("restart length", 16'(cnt), 16'd77);
      check("restart flags", 16'(status), 16'h0001);
      for (int j = 0; j < 7; j++) begin
         if (ev_halt[j] == 1) go_halt(1'($urandom_range(1)), 1'b0);
         evt(ev_kind[j]);
         check("event flags", 16'(status), 16'(ev_flags[j]));
      end
      watchdog_clear_instr = 1'b1;
      step(1);
      watchdog_clear_instr = 1'b0;
      check("clear flags", 16'(status), 16'h0003);
      for (int j = 0; j < 6; j++) begin
         irq = 1'($urandom_range(1));
         cfg.high_osc_select = 1'($urandom_range(1));
         go_halt(j[0], irq);
         kick(3'(j % 2));
         step(2);
         check("timer in halt", 16'(osc_halted), 16'h0001);
         kick(3'(2 + $urandom_range(2)));
         resume(j[0] ? 513 : 17);
      end
      for (int s = 0; s < 5; s++) begin
         irq = 1'($urandom_range(1));
         cfg.high_osc_select = 1'($urandom_range(1));
         global_irq_enabled = irq;
         standby_request = 1'b1;
         step(1);
         standby_request = 1'b0;
         global_irq_enabled = ~irq;
         kick(3'(s));
         resume(1);
      end
      complete_run();
   end
endmodule : mcu_reset_wake_sequencer_tb_top
